// ### scasm_chan.sv
// smart-card async serial channel: registers, transmitter and receiver
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps
module scasm_chan import scasm_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic serial_in_pin,
	input wire logic external_baud_clock_pin,
	output logic serial_out_pin,
	output logic serial_out_pin_oe,
	output logic tx_int_req,
	output logic rx_int_req
);
	logic [7:0] mode_reg;
	logic [7:0] brg;
	logic [7:0] ctrl0;
	logic [7:0] ctrl1;
	logic [7:0] tx_buf;
	logic tx_full;
	logic [7:0] rx_buf;
	logic rx_full;
	logic ovr_flag;
	logic frm_flag;
	logic par_flag;
	logic chan_on;
	logic tick;
	logic invert;
	logic msb_first;
	logic par_on;
	logic par_even;
	logic err_sig_en;
	scasm_tx_e tx_st;
	logic [3:0] tx_tc;
	logic [2:0] tx_bc;
	logic [7:0] tx_sh;
	logic tx_line;
	logic tx_load;
	scasm_rx_e rx_st;
	logic [3:0] rx_tc;
	logic [2:0] rx_bc;
	logic [7:0] rx_sh;
	logic rx_par_bad;
	logic rx_in_q;
	logic rx_done;
	logic rx_frm_bad;
	logic err_drive;
	logic next_out;
	logic rx_read;

	// channel only runs in the 8-bit async mode with flow control off
	assign chan_on = (mode_reg[MODE_SMD_LSB +: 3] == SMD_ASYNC8) && ctrl0[C0_FLOW_DIS];
	assign invert = ctrl1[C1_INVERT];
	assign msb_first = ctrl0[C0_MSB_FIRST];
	assign par_on = mode_reg[MODE_PRYE];
	assign par_even = mode_reg[MODE_PRY];
	assign err_sig_en = ctrl1[C1_ERR_SIG_EN];
	assign tx_load = (tx_st == TX_IDLE) && chan_on && ctrl1[C1_TX_EN] && tx_full;
	assign rx_read = rd && (addr == OFS_RXBUF);

	scasm_baud u_baud (
		.clk(clk),
		.sys_rst(sys_rst),
		.run(chan_on),
		.ext_sel(mode_reg[MODE_CKDIR]),
		.clk_sel(ctrl0[C0_CLK_LSB +: 2]),
		.ext_pin(external_baud_clock_pin),
		.divisor(brg),
		.tick(tick)
	);

	// software-written configuration registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_reg <= RST_MODE;
			brg <= RST_BRG;
			ctrl0 <= RST_CTRL0;
			ctrl1 <= RST_CTRL1;
		end else if (wr) begin
			case (addr)
				OFS_MODE: mode_reg <= {1'b0, wdata[6:0]};
				OFS_BRG: brg <= wdata[7:0];
				OFS_CTRL0: ctrl0 <= wdata[7:0];
				OFS_CTRL1: ctrl1 <= wdata[7:0];
				default: ;
			endcase
		end
	end

	// transmit buffer; data inverted on write when selected
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_buf <= 8'h00;
			tx_full <= 1'b0;
		end else if (wr && addr == OFS_TXBUF) begin
			tx_buf <= wdata[7:0] ^ {8{invert}};
			tx_full <= 1'b1;
		end else if (tx_load) begin
			tx_full <= 1'b0;
		end
	end

	// transmit state machine, sixteen ticks per bit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_st <= TX_IDLE;
			tx_tc <= 4'h0;
			tx_bc <= 3'h0;
			tx_sh <= 8'h00;
			tx_line <= 1'b1;
		end else if (!chan_on) begin
			tx_st <= TX_IDLE;
			tx_line <= 1'b1;
		end else if (tx_load) begin
			tx_st <= TX_START;
			tx_tc <= 4'h0;
			tx_bc <= 3'h0;
			tx_sh <= tx_buf;
			tx_line <= 1'b0;
		end else if (tick && tx_st != TX_IDLE) begin
			tx_tc <= tx_tc + 4'h1;
			if (tx_tc == TICK_LAST) begin
				case (tx_st)
					TX_START: begin
						tx_st <= TX_DATA;
						tx_line <= msb_first ? tx_sh[7] : tx_sh[0];
					end
					TX_DATA: begin
						tx_bc <= tx_bc + 3'h1;
						if (tx_bc == BIT_LAST) begin
							tx_st <= par_on ? TX_PAR : TX_STOP;
							tx_line <= par_on ? (^tx_sh ^ ~par_even) : 1'b1;
						end else if (msb_first) begin
							tx_line <= tx_sh[3'h6 - tx_bc];
						end else begin
							tx_line <= tx_sh[tx_bc + 3'h1];
						end
					end
					TX_PAR: begin
						tx_st <= TX_STOP;
						tx_line <= 1'b1;
					end
					TX_STOP: begin
						tx_st <= err_sig_en ? TX_GUARD : TX_IDLE;
						tx_line <= 1'b1;
					end
					TX_GUARD: begin
						tx_st <= TX_IDLE;
					end
					default: tx_st <= TX_IDLE;
				endcase
			end
		end
	end

	// transmit interrupt: buffer-empty on load, or completion of the frame
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_int_req <= 1'b0;
		end else if (!ctrl1[C1_TX_IRQ_SRC]) begin
			tx_int_req <= tx_load;
		end else if (err_sig_en) begin
			tx_int_req <= tick && tx_st == TX_GUARD && tx_tc == TICK_MID;
		end else begin
			tx_int_req <= tick && tx_st == TX_STOP && tx_tc == TICK_LAST;
		end
	end

	// receive state machine, sampling each bit at mid-period
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_st <= RX_IDLE;
			rx_tc <= 4'h0;
			rx_bc <= 3'h0;
			rx_sh <= 8'h00;
			rx_par_bad <= 1'b0;
			rx_in_q <= 1'b1;
			rx_done <= 1'b0;
			rx_frm_bad <= 1'b0;
			err_drive <= 1'b0;
		end else begin
			rx_in_q <= serial_in_pin;
			rx_done <= 1'b0;
			if (!chan_on || !ctrl1[C1_RX_EN]) begin
				rx_st <= RX_IDLE;
				err_drive <= 1'b0;
			end else case (rx_st)
				RX_IDLE: begin
					if (rx_in_q && !serial_in_pin) begin
						rx_st <= RX_START;
						rx_tc <= 4'h0;
						rx_bc <= 3'h0;
						rx_par_bad <= 1'b0;
					end
				end
				RX_START: begin
					if (tick) begin
						rx_tc <= rx_tc + 4'h1;
						if (rx_tc == TICK_MID) begin
							rx_tc <= 4'h0;
							rx_st <= serial_in_pin ? RX_IDLE : RX_DATA;
						end
					end
				end
				RX_DATA: begin
					if (tick) begin
						rx_tc <= rx_tc + 4'h1;
						if (rx_tc == TICK_LAST) begin
							rx_bc <= rx_bc + 3'h1;
							rx_par_bad <= rx_par_bad ^ serial_in_pin;
							if (msb_first) begin
								rx_sh <= {rx_sh[6:0], serial_in_pin};
							end else begin
								rx_sh <= {serial_in_pin, rx_sh[7:1]};
							end
							if (rx_bc == BIT_LAST) begin
								rx_st <= par_on ? RX_PAR : RX_STOP;
							end
						end
					end
				end
				RX_PAR: begin
					if (tick) begin
						rx_tc <= rx_tc + 4'h1;
						if (rx_tc == TICK_LAST) begin
							rx_par_bad <= rx_par_bad ^ serial_in_pin ^ ~par_even;
							rx_st <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (tick) begin
						rx_tc <= rx_tc + 4'h1;
						if (rx_tc == TICK_LAST) begin
							rx_done <= 1'b1;
							rx_frm_bad <= !serial_in_pin;
							rx_tc <= 4'h0;
							if (rx_par_bad && par_on && err_sig_en) begin
								rx_st <= RX_ERRSIG;
								err_drive <= 1'b1;
							end else begin
								rx_st <= RX_IDLE;
							end
						end
					end
				end
				RX_ERRSIG: begin
					if (tick) begin
						rx_tc <= rx_tc + 4'h1;
						if (rx_tc == TICK_LAST) begin
							err_drive <= 1'b0;
							rx_st <= RX_IDLE;
						end
					end
				end
				default: rx_st <= RX_IDLE;
			endcase
		end
	end

	// receive buffer, error flags and receive interrupt
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_buf <= 8'h00;
			rx_full <= 1'b0;
			ovr_flag <= 1'b0;
			frm_flag <= 1'b0;
			par_flag <= 1'b0;
			rx_int_req <= 1'b0;
		end else begin
			rx_int_req <= 1'b0;
			if (rx_done) begin
				rx_buf <= rx_sh;
				rx_full <= 1'b1; // set wins over a same-cycle read
				ovr_flag <= rx_full && !rx_read;
				frm_flag <= rx_frm_bad;
				par_flag <= rx_par_bad && par_on;
				rx_int_req <= !(rx_full && !rx_read);
			end else if (rx_read) begin
				rx_full <= 1'b0;
				ovr_flag <= 1'b0;
			end
		end
	end

	// output pin: error signal overrides transmit; open drain releases highs
	assign next_out = tx_line && !err_drive;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			serial_out_pin <= 1'b1;
			serial_out_pin_oe <= 1'b1;
		end else begin
			serial_out_pin <= next_out;
			serial_out_pin_oe <= !ctrl0[C0_OPEN_DRAIN] || !next_out;
		end
	end

	// read data, one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			case (addr)
				OFS_MODE: rdata <= {8'h00, mode_reg};
				OFS_BRG: rdata <= {8'h00, brg};
				OFS_TXBUF: rdata <= {8'h00, tx_buf};
				OFS_RXBUF: rdata <= {ovr_flag | frm_flag | par_flag, par_flag, frm_flag, ovr_flag,
					4'h0, rx_buf ^ {8{invert}}};
				OFS_CTRL0: rdata <= {8'h00, ctrl0};
				OFS_CTRL1: rdata <= {8'h00, ctrl1[7:4], rx_full, ctrl1[2], !tx_full, ctrl1[0]};
				OFS_PIN: rdata <= {15'h0000, serial_in_pin};
				default: rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end
endmodule : scasm_chan

// ### scasm_pkg.sv
// constants for the smart-card async serial channel
package scasm_pkg;
	// register offsets
	localparam logic [2:0] OFS_MODE = 3'h0;
	localparam logic [2:0] OFS_BRG = 3'h1;
	localparam logic [2:0] OFS_TXBUF = 3'h2;
	localparam logic [2:0] OFS_RXBUF = 3'h3;
	localparam logic [2:0] OFS_CTRL0 = 3'h4;
	localparam logic [2:0] OFS_CTRL1 = 3'h5;
	localparam logic [2:0] OFS_PIN = 3'h6;
	// mode register fields
	localparam int MODE_SMD_LSB = 0;
	localparam int MODE_CKDIR = 3;
	localparam int MODE_STPS = 4;
	localparam int MODE_PRY = 5;
	localparam int MODE_PRYE = 6;
	localparam logic [2:0] SMD_ASYNC8 = 3'h5;
	// control 0 fields
	localparam int C0_CLK_LSB = 0;
	localparam int C0_FLOW_DIS = 4;
	localparam int C0_OPEN_DRAIN = 5;
	localparam int C0_MSB_FIRST = 7;
	// control 1 fields
	localparam int C1_TX_EN = 0;
	localparam int C1_TX_EMPTY = 1;
	localparam int C1_RX_EN = 2;
	localparam int C1_RX_FULL = 3;
	localparam int C1_TX_IRQ_SRC = 4;
	localparam int C1_INVERT = 6;
	localparam int C1_ERR_SIG_EN = 7;
	// receive buffer status fields
	localparam int RB_OVERRUN = 12;
	localparam int RB_FRAMING = 13;
	localparam int RB_PARITY = 14;
	localparam int RB_ERR_SUM = 15;
	// prescaled clock selections
	localparam logic [1:0] CLK_F1 = 2'h0;
	localparam logic [1:0] CLK_F8 = 2'h1;
	localparam logic [1:0] CLK_F32 = 2'h2;
	// reset values
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_BRG = 8'h00;
	localparam logic [7:0] RST_CTRL0 = 8'h00;
	localparam logic [7:0] RST_CTRL1 = 8'h00;
	// bit timing in divided-clock ticks
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [4:0] DIV8_LAST = 5'h07;
	localparam logic [4:0] DIV32_LAST = 5'h1F;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_GUARD} scasm_tx_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_ERRSIG} scasm_rx_e;
endpackage : scasm_pkg

// ### scasm_baud.sv
// bit rate generator: prescaler or external clock, then divide by n+1
`timescale 1ns/10ps
module scasm_baud import scasm_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic ext_sel,
	input wire logic [1:0] clk_sel,
	input wire logic ext_pin,
	input wire logic [7:0] divisor,
	output logic tick
);
	logic [4:0] pre;
	logic ext_q;
	logic src_en;
	logic [7:0] cnt;

	// prescaler and external edge detect
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pre <= 5'h00;
			ext_q <= 1'b0;
		end else begin
			pre <= pre + 5'h01;
			ext_q <= ext_pin;
		end
	end

	// source enable for the selected clock
	always_comb begin
		if (ext_sel) begin
			src_en = ext_pin & ~ext_q;
		end else begin
			case (clk_sel)
				CLK_F1: src_en = 1'b1;
				CLK_F8: src_en = (pre[2:0] == DIV8_LAST[2:0]);
				CLK_F32: src_en = (pre == DIV32_LAST);
				default: src_en = 1'b1;
			endcase
		end
	end

	// divide source by divisor plus one, giving sixteen ticks per bit
	always_ff @(posedge clk) begin
		if (sys_rst || !run) begin
			cnt <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (src_en) begin
				if (cnt >= divisor) begin
					cnt <= 8'h00;
					tick <= 1'b1;
				end else begin
					cnt <= cnt + 8'h01;
				end
			end
		end
	end
endmodule : scasm_baud

// ### scasm_chan_chk.sv
// port checker for the smart-card serial channel
`timescale 1ns/10ps
module scasm_chan_chk import scasm_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic serial_in_pin,
	input wire logic external_baud_clock_pin,
	input wire logic serial_out_pin,
	input wire logic serial_out_pin_oe,
	input wire logic tx_int_req,
	input wire logic rx_int_req
);
	logic od;
	logic src;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// shadow copies of open drain and tx irq source
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			od <= 1'b0;
			src <= 1'b0;
		end else if (wr && addr == OFS_CTRL0) begin
			od <= wdata[C0_OPEN_DRAIN];
		end else if (wr && addr == OFS_CTRL1) begin
			src <= wdata[C1_TX_IRQ_SRC];
		end
	end
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data not zero outside a read");
	a_unmapped_read: assert property (rd && addr == 3'h7 |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_pin_read: assert property (rd && addr == OFS_PIN |=> rdata == {15'h0000, $past(serial_in_pin)})
		else $error("pin read wrong");
	a_tx_irq_gap: assert property (tx_int_req |=> !tx_int_req [*8])
		else $error("tx irq not a single pulse");
	a_rx_irq_gap: assert property (rx_int_req |=> !rx_int_req [*8])
		else $error("rx irq not a single pulse");
	a_open_drain: assert property (od && $past(od) && serial_out_pin |-> !serial_out_pin_oe)
		else $error("open drain drives high");
	a_low_driven: assert property (!serial_out_pin |-> serial_out_pin_oe)
		else $error("low level not driven");
	a_txirq_line_high: assert property (src && $past(src) && tx_int_req |-> serial_out_pin && $past(serial_out_pin, 4))
		else $error("tx complete irq outside stop or guard");
endmodule : scasm_chan_chk

// ### scasm_card.sv
// memory card model on the shared pulled-up data line
`timescale 1ns/10ps
module scasm_card (
	input wire logic clk,
	input wire logic line,
	output logic pull_low
);
	int bit_len = 32;
	logic nack = 1'b0;
	logic busy = 1'b0;
	logic stop_val = 1'b1;
	logic [9:0] got_q[$];
	initial pull_low = 1'b0;
	// send start, data, parity, stop; a released line rises by the pull-up; stop_val low forces a bad stop
	task send(input logic [8:0] d);
		logic [9:0] f;
		f = {stop_val, d};
		busy = 1'b1;
		@(posedge clk);
		pull_low <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			repeat (bit_len) @(posedge clk);
			pull_low <= ~f[i];
		end
		repeat (bit_len) @(posedge clk);
		pull_low <= 1'b0;
		repeat (2 * bit_len) @(posedge clk);
		busy = 1'b0;
	endtask : send
	// capture channel frames mid-bit, answer with an error pulse on request
	always begin : catch
		logic [9:0] f;
		@(negedge line);
		if (!busy) begin
			repeat (bit_len / 2) @(posedge clk);
			for (int i = 0; i < 10; i++) begin
				repeat (bit_len) @(posedge clk);
				f[i] = line;
			end
			got_q.push_back(f);
			if (nack) begin
				repeat (bit_len / 2) @(posedge clk);
				pull_low <= 1'b1;
				repeat (bit_len) @(posedge clk);
				pull_low <= 1'b0;
			end
		end
	end
endmodule : scasm_card

// ### scasm_chan_tb.sv
// self-checking bench for the smart-card serial channel
`timescale 1ns/10ps
module scasm_chan_tb import scasm_pkg::*;;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic out, oe, tx_irq, rx_irq, pull_low;
	wire line = ~pull_low & ~(oe & ~out);
	int n_errors = 0;
	int check_count = 0;
	int tx_cnt = 0;
	int rx_cnt = 0;
	int low_cnt = 0;
	int low_run = 0;
	int irq_low = 0;
	logic ext_clk = 1'b0;
	int t;
	logic [31:0] seed = 32'hA8D5C2A3;
	logic [9:0] exp_q[$];
	logic [15:0] v;
	logic [8:0] f;
	logic [7:0] b;
	always #10 clk = ~clk;
	// count irq pulses and cycles the channel pulls the line low; note how long the line was low at a tx irq
	always @(posedge clk) begin
		if (tx_irq === 1'b1) tx_cnt++;
		if (tx_irq === 1'b1) irq_low = low_run;
		if (rx_irq === 1'b1) rx_cnt++;
		if (oe === 1'b1 && out === 1'b0) low_cnt++;
		low_run = (line === 1'b0) ? low_run + 1 : 0;
	end
	// free-running external baud clock, one rising edge every two cycles
	always @(posedge clk) ext_clk <= ~ext_clk;
	scasm_chan u_dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .serial_in_pin(line), .external_baud_clock_pin(ext_clk), .serial_out_pin(out),
		.serial_out_pin_oe(oe), .tx_int_req(tx_irq), .rx_int_req(rx_irq));
	scasm_card u_card (.clk(clk), .line(line), .pull_low(pull_low));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// line order data plus parity for either convention
	function automatic logic [8:0] enc(input logic [7:0] x, input logic inv);
		logic [7:0] d;
		for (int i = 0; i < 8; i++)
			d[i] = inv ? ~x[7 - i] : x[i];
		return {inv ? ~^d : ^d, d};
	endfunction : enc
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask : chk
	task wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= {8'h00, d};
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task rreg(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg
	task automatic wait_cnt(ref int c, input int want);
		repeat (20000) if (c < want) @(negedge clk);
		if (c < want) begin
			n_errors++;
			$display("wrong value irq count expected %0d seen %0d", want, c);
			stop_test();
		end
	endtask : wait_cnt
	task tx_byte(input logic inv);
		seed = lfsr(seed);
		exp_q.push_back({1'b1, enc(seed[7:0], inv)});
		wreg(OFS_TXBUF, seed[7:0]);
	endtask : tx_byte
	task drain;
		while (exp_q.size() > 0)
			chk("frame", {6'h00, exp_q.pop_front()}, {6'h00, u_card.got_q.pop_front()});
	endtask : drain
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rreg(OFS_CTRL1, v);
		chk("ctrl1", 16'h0002, v);
		rreg(3'h7, v);
		chk("unmapped", 16'h0000, v);
		wreg(OFS_BRG, 8'hFF);
		rreg(OFS_BRG, v);
		chk("divisor", 16'h00FF, v);
		$display("register access done");
		wreg(OFS_BRG, 8'h01);
		for (int inv = 0; inv < 2; inv++) begin
			wreg(OFS_MODE, inv ? 8'h45 : 8'h65);
			wreg(OFS_CTRL0, inv ? 8'hB0 : 8'h30);
			wreg(OFS_CTRL1, inv ? 8'h51 : 8'h11);
			t = tx_cnt;
			tx_byte(inv[0]);
			tx_byte(inv[0]);
			wait_cnt(tx_cnt, t + 2);
			drain();
			wreg(OFS_CTRL1, inv ? 8'h54 : 8'h14);
			t = rx_cnt;
			seed = lfsr(seed);
			b = seed[7:0];
			u_card.send(enc(b, inv[0]));
			wait_cnt(rx_cnt, t + 1);
			rreg(OFS_RXBUF, v);
			chk("rx data", {8'h00, b}, v);
			$display("convention %0d done", inv);
		end
		t = rx_cnt;
		seed = lfsr(seed);
		u_card.send(enc(seed[7:0], 1'b1));
		seed = lfsr(seed);
		b = seed[7:0];
		u_card.send(enc(b, 1'b1));
		chk("rx irq count", 16'(t + 1), 16'(rx_cnt));
		rreg(OFS_RXBUF, v);
		chk("overrun", {8'h90, b}, v);
		$display("overrun done");
		wreg(OFS_BRG, 8'h00);
		wreg(OFS_CTRL1, 8'h51);
		// eight, then thirty-two clocks per tick with divisor zero
		for (int k = 1; k < 3; k++) begin
			wreg(OFS_CTRL0, (k == 1) ? 8'hB1 : 8'hB2);
			u_card.bit_len = (k == 1) ? 128 : 512;
			t = tx_cnt;
			tx_byte(1'b1);
			wait_cnt(tx_cnt, t + 1);
			drain();
		end
		u_card.bit_len = 32;
		wreg(OFS_CTRL0, 8'hB0);
		wreg(OFS_BRG, 8'h01);
		$display("prescaler done");
		// external clock at half rate, divisor one; irq source set to load into the shifter
		wreg(OFS_MODE, 8'h4D);
		wreg(OFS_CTRL1, 8'h41);
		u_card.bit_len = 64;
		t = tx_cnt;
		tx_byte(1'b1);
		wait_cnt(tx_cnt, t + 1);
		chk("irq before frame", 16'h0000, 16'(u_card.got_q.size()));
		repeat (1024) @(posedge clk);
		drain();
		u_card.bit_len = 32;
		wreg(OFS_MODE, 8'h45);
		$display("external clock done");
		wreg(OFS_CTRL1, 8'hD1);
		u_card.nack = 1'b1;
		t = tx_cnt;
		tx_byte(1'b1);
		wait_cnt(tx_cnt, t + 1);
		chk("irq at error time", 16'h0001, 16'(irq_low >= 8 && irq_low < 32));
		rreg(OFS_PIN, v);
		chk("card error seen", 16'h0000, v);
		drain();
		u_card.nack = 1'b0;
		repeat (64) @(posedge clk);
		$display("card error done");
		wreg(OFS_CTRL1, 8'hC4);
		low_cnt = 0;
		seed = lfsr(seed);
		b = seed[7:0];
		f = enc(b, 1'b1);
		f[8] = ~f[8];
		u_card.send(f);
		chk("error pulse", 16'h0020, 16'(low_cnt));
		rreg(OFS_RXBUF, v);
		chk("parity error", {8'hC0, b}, v);
		$display("parity error done");
		u_card.stop_val = 1'b0;
		seed = lfsr(seed);
		b = seed[7:0];
		u_card.send(enc(b, 1'b1));
		rreg(OFS_RXBUF, v);
		chk("framing error", {8'hA0, b}, v);
		u_card.stop_val = 1'b1;
		wreg(OFS_CTRL1, 8'h00);
		$display("framing error done");
		stop_test();
	end
endmodule : scasm_chan_tb
bind scasm_chan scasm_chan_chk u_chk (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .serial_in_pin(serial_in_pin), .external_baud_clock_pin(external_baud_clock_pin),
	.serial_out_pin(serial_out_pin), .serial_out_pin_oe(serial_out_pin_oe), .tx_int_req(tx_int_req),
	.rx_int_req(rx_int_req));
